// ==== ovxp_protection.sv ====
/*
 Overexcitation protection core: sample-rate divider, U/f ratio, timing
 characteristics, thermal accumulator and final start/alarm/trip decision.
 Assumes settings are held steady by the host and phase samples are valid
 in every cycle; all delay settings are in milliseconds.
*/
`timescale 1ns/1ps
module ovxp_protection #(
	parameter int SAMPLE_DIV = ovxp_pkg::SAMPLE_DIV
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic signed [ovxp_pkg::VOLT_W-1:0] phaseVoltA,
	input wire logic signed [ovxp_pkg::VOLT_W-1:0] phaseVoltB,
	input wire logic signed [ovxp_pkg::VOLT_W-1:0] phaseVoltC,
	input wire logic [1:0] pairSel,
	input wire logic [ovxp_pkg::FLUX_W-1:0] ratedFlux,
	input wire logic [1:0] mode,
	input wire logic [ovxp_pkg::RATIO_W-1:0] upperPickupRatio,
	input wire logic [ovxp_pkg::RATIO_W-1:0] lowerPickupRatio,
	input wire logic [5:0] timeMult,
	input wire logic [ovxp_pkg::TIME_W-1:0] dtDelayMs,
	input wire logic [ovxp_pkg::TIME_W-1:0] dropOffMs,
	input wire logic [ovxp_pkg::TIME_W-1:0] minDelayMs,
	input wire logic [ovxp_pkg::TIME_W-1:0] maxDelayMs,
	input wire logic [ovxp_pkg::TIME_W-1:0] coolTimeMs,
	input wire logic [ovxp_pkg::TIME_W-1:0] alarmDelayMs,
	input wire logic [ovxp_pkg::PTS-1:0][ovxp_pkg::RATIO_W-1:0] curveRatio,
	input wire logic [ovxp_pkg::PTS-1:0][ovxp_pkg::TIME_W-1:0] curveDelayMs,
	output logic [ovxp_pkg::FLUX_W-1:0] fluxMagnitude,
	output logic [ovxp_pkg::RATIO_W-1:0] ratioPct,
	output logic [ovxp_pkg::CNT_W-1:0] thermalLevel,
	output logic startOut,
	output logic alarmOut,
	output logic tripOut
);
	localparam int CW = ovxp_pkg::CNT_W;
	localparam int DW = ovxp_pkg::DIV_W;
	localparam int RW = ovxp_pkg::RATIO_W;
	localparam int TW = ovxp_pkg::TIME_W;
	localparam int SW = ovxp_pkg::SEG_W;
	localparam int NP = ovxp_pkg::PTS;

	function automatic logic [CW-1:0] toS(input logic [TW-1:0] ms);
		toS = CW'(ms) * CW'(ovxp_pkg::SAMPLES_PER_MS);
	endfunction

	ovxp_pkg::ovxp_state_t state;
	ovxp_pkg::ovxp_mode_t modeSel;
	ovxp_div_if dv();
	logic [CW-1:0] divCnt;
	logic sampleEn;
	logic sampleDly;
	logic magValid;
	logic divPending;
	logic divState;
	logic [CW-1:0] qSat;
	logic [CW-1:0] rawT;
	logic [CW-1:0] tOp;
	logic [CW-1:0] inc;
	logic [CW-1:0] dec;
	logic [CW-1:0] dtCnt;
	logic [CW-1:0] dropCnt;
	logic [CW-1:0] alarmCnt;
	logic [CW-1:0] dtS;
	logic [CW-1:0] dropS;
	logic [CW-1:0] minS;
	logic [CW-1:0] maxS;
	logic [CW-1:0] coolS;
	logic [CW-1:0] alarmS;
	logic [CW-1:0] tSpan;
	logic [RW-1:0] thr;
	logic [RW-1:0] dev;
	logic [5:0] tmsC;
	logic [NP-2:0] inSeg;
	logic [SW-1:0] seg;
	logic pick;
	logic dropped;
	logic aboveHigh;
	logic decide;
	logic next_start;
	logic dtTrip;
	logic invTrip;

	assign modeSel = ovxp_pkg::ovxp_mode_t'(mode);
	assign dtS = toS(dtDelayMs);
	assign dropS = toS(dropOffMs);
	assign minS = toS(minDelayMs);
	assign maxS = toS(maxDelayMs);
	assign coolS = toS(coolTimeMs);
	assign alarmS = toS(alarmDelayMs);

	ovxp_flux u_flux (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.sampleEn(sampleEn),
		.voltA(phaseVoltA),
		.voltB(phaseVoltB),
		.voltC(phaseVoltC),
		.pairSel(pairSel),
		.fluxMag(fluxMagnitude),
		.magValid(magValid)
	);

	ovxp_divider u_div (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.div(dv)
	);

	// a sample arriving while the pipeline is still busy is skipped
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			divCnt <= '0;
			sampleEn <= 1'b0;
			sampleDly <= 1'b0;
		end else begin
			sampleDly <= sampleEn;
			if (divCnt >= CW'(SAMPLE_DIV - 1)) begin
				divCnt <= '0;
				sampleEn <= 1'b1;
			end else begin
				divCnt <= divCnt + CW'(1'b1);
				sampleEn <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ovxp_pkg::ST_IDLE;
		end else begin
			case (state)
				ovxp_pkg::ST_IDLE: if (sampleDly) state <= ovxp_pkg::ST_RATIO;
				ovxp_pkg::ST_RATIO: if (dv.done) state <= ovxp_pkg::ST_CURVE;
				ovxp_pkg::ST_CURVE: if (dv.done) state <= ovxp_pkg::ST_HEAT;
				ovxp_pkg::ST_HEAT: if (dv.done) state <= ovxp_pkg::ST_COOL;
				ovxp_pkg::ST_COOL: if (dv.done) state <= ovxp_pkg::ST_DECIDE;
				default: state <= ovxp_pkg::ST_IDLE;
			endcase
		end
	end

	assign divState = (state != ovxp_pkg::ST_IDLE) && (state != ovxp_pkg::ST_DECIDE);
	assign dv.start = divState && !divPending;
	assign decide = (state == ovxp_pkg::ST_DECIDE);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			divPending <= 1'b0;
		end else if (dv.start) begin
			divPending <= 1'b1;
		end else if (dv.done) begin
			divPending <= 1'b0;
		end
	end

	// custom segment search; points are expected in ascending ratio order
	generate
		for (genvar i = 0; i < NP - 1; i++) begin : g_seg
			assign inSeg[i] = (ratioPct >= curveRatio[i]) && (ratioPct < curveRatio[i+1]);
		end
	endgenerate

	always_comb begin
		seg = '0;
		for (int i = 0; i < NP - 1; i++) begin
			if (inSeg[i]) seg = SW'(i);
		end
	end

	assign tSpan = toS(curveDelayMs[seg]) - toS(curveDelayMs[seg + SW'(1'b1)]);
	assign dev = ratioPct - upperPickupRatio;

	assign tmsC = (timeMult < ovxp_pkg::TMS_MIN) ? ovxp_pkg::TMS_MIN :
		((timeMult > ovxp_pkg::TMS_MAX) ? ovxp_pkg::TMS_MAX : timeMult);

	always_comb begin
		case (state)
			ovxp_pkg::ST_RATIO: begin
				dv.dividend = DW'(fluxMagnitude) * DW'(ovxp_pkg::RATIO_SCALE);
				dv.divisor = DW'(ratedFlux);
			end
			ovxp_pkg::ST_CURVE: begin
				if (modeSel == ovxp_pkg::MODE_IEEE) begin
					dv.dividend = ovxp_pkg::IEEE_NUM * DW'(tmsC);
					dv.divisor = DW'(dev) * DW'(dev);
				end else begin
					dv.dividend = DW'(tSpan) * DW'(ratioPct - curveRatio[seg]);
					dv.divisor = DW'(curveRatio[seg + SW'(1'b1)] - curveRatio[seg]);
				end
			end
			ovxp_pkg::ST_HEAT: begin
				dv.dividend = DW'(ovxp_pkg::ACC_FULL);
				dv.divisor = DW'(tOp);
			end
			ovxp_pkg::ST_COOL: begin
				dv.dividend = DW'(ovxp_pkg::ACC_FULL);
				dv.divisor = DW'(coolS);
			end
			default: begin
				dv.dividend = '0;
				dv.divisor = '0;
			end
		endcase
	end

	always_comb begin
		qSat = (|dv.quotient[DW-1:CW]) ? '1 : dv.quotient[CW-1:0];
		case (modeSel)
			ovxp_pkg::MODE_IEEE: begin
				rawT = (ratioPct > upperPickupRatio) ? qSat : maxS;
				if (ratioPct > lowerPickupRatio && rawT > maxS) rawT = maxS;
				if (ratioPct > upperPickupRatio && rawT < minS) rawT = minS;
			end
			ovxp_pkg::MODE_CUSTOM: begin
				if (ratioPct >= curveRatio[NP-1]) begin
					rawT = toS(curveDelayMs[NP-1]);
				end else begin
					rawT = toS(curveDelayMs[seg]) - qSat;
				end
			end
			default: rawT = dtS;
		endcase
		if (rawT == '0) rawT = CW'(1'b1);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ratioPct <= '0;
			tOp <= '0;
			inc <= '0;
			dec <= '0;
		end else if (dv.done) begin
			case (state)
				ovxp_pkg::ST_RATIO: ratioPct <= (|dv.quotient[DW-1:RW]) ? '1 : dv.quotient[RW-1:0];
				ovxp_pkg::ST_CURVE: tOp <= rawT;
				ovxp_pkg::ST_HEAT: inc <= qSat;
				ovxp_pkg::ST_COOL: dec <= qSat;
				default: tOp <= tOp;
			endcase
		end
	end

	assign thr = (modeSel == ovxp_pkg::MODE_IEEE) ? lowerPickupRatio :
		((modeSel == ovxp_pkg::MODE_CUSTOM) ? curveRatio[0] : upperPickupRatio);

	assign pick = magValid && (ratioPct > thr);
	assign dropped = (CW'(ratioPct) * CW'(ovxp_pkg::DROP_DEN))
		< (CW'(thr) * CW'(ovxp_pkg::DROP_NUM));
	assign aboveHigh = magValid && (ratioPct > upperPickupRatio);
	assign next_start = pick || (startOut && !dropped);
	assign dtTrip = (modeSel != ovxp_pkg::MODE_IEEE) && aboveHigh && (dtCnt >= dtS);
	assign invTrip = (modeSel != ovxp_pkg::MODE_DT) && (thermalLevel >= ovxp_pkg::ACC_FULL);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			startOut <= 1'b0;
			alarmOut <= 1'b0;
			alarmCnt <= '0;
		end else if (decide) begin
			startOut <= next_start;
			alarmCnt <= !next_start ? '0 : (alarmCnt == '1 ? alarmCnt : alarmCnt + CW'(1'b1));
			alarmOut <= next_start && startOut && (alarmCnt >= alarmS);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dtCnt <= '0;
			dropCnt <= '0;
		end else if (decide) begin
			if (aboveHigh) begin
				dtCnt <= (dtCnt == '1) ? dtCnt : dtCnt + CW'(1'b1);
				dropCnt <= '0;
			end else if (dropped) begin
				if (dropCnt >= dropS) begin
					dtCnt <= '0;
				end else begin
					dropCnt <= dropCnt + CW'(1'b1);
				end
			end else begin
				dropCnt <= '0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			thermalLevel <= '0;
		end else if (decide) begin
			if (modeSel == ovxp_pkg::MODE_DT) begin
				thermalLevel <= '0;
			end else if (pick) begin
				thermalLevel <= (ovxp_pkg::ACC_FULL - thermalLevel <= inc) ?
					ovxp_pkg::ACC_FULL : thermalLevel + inc;
			end else if (dropped) begin
				thermalLevel <= (thermalLevel <= dec) ? '0 : thermalLevel - dec;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tripOut <= 1'b0;
		end else if (decide) begin
			tripOut <= pick && (dtTrip || invTrip);
		end
	end

	a_trip_started: assert property (@(posedge ref_clk) disable iff (!nrst)
		tripOut |-> startOut)
		else $error("trip without start");
	a_alarm_after_start: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(alarmOut) |-> $past(startOut) && startOut)
		else $error("alarm not preceded by start");
	a_start_needs_mag: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(startOut) |-> magValid && $past(ratioPct > thr))
		else $error("start without valid magnitude");
	a_dt_trip_time: assert property (@(posedge ref_clk) disable iff (!nrst)
		decide && modeSel == ovxp_pkg::MODE_DT && aboveHigh && dtCnt >= dtS |=> tripOut)
		else $error("definite trip missed");
	a_ieee_max_cap: assert property (@(posedge ref_clk) disable iff (!nrst)
		state == ovxp_pkg::ST_CURVE && dv.done && modeSel == ovxp_pkg::MODE_IEEE
		&& ratioPct > lowerPickupRatio && maxS != '0 |=> tOp <= maxS)
		else $error("maximum delay not applied");
	a_ieee_min_floor: assert property (@(posedge ref_clk) disable iff (!nrst)
		state == ovxp_pkg::ST_CURVE && dv.done && modeSel == ovxp_pkg::MODE_IEEE
		&& ratioPct > upperPickupRatio |=> tOp >= minS)
		else $error("minimum delay not applied");
	a_cool_ramp: assert property (@(posedge ref_clk) disable iff (!nrst)
		decide && !pick && dropped && thermalLevel != '0 |=> thermalLevel < $past(thermalLevel))
		else $error("accumulator not cooling");
	a_tms_bounds: assert property (@(posedge ref_clk) disable iff (!nrst)
		tmsC >= ovxp_pkg::TMS_MIN && tmsC <= ovxp_pkg::TMS_MAX)
		else $error("time multiplier out of range");
	a_heat_full: assert property (@(posedge ref_clk) disable iff (!nrst)
		decide && pick && modeSel != ovxp_pkg::MODE_DT
		&& thermalLevel >= ovxp_pkg::ACC_FULL |=> ##[0:1] tripOut || !startOut)
		else $error("full accumulator did not trip");
	a_sample_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
		sampleEn |=> !sampleEn [*2])
		else $error("sample enable too frequent");
endmodule

// ==== ovxp_pkg.sv ====
/*
 Shared constants and types of the overexcitation protection core.
 Assumes a 100 MHz core clock and a fixed 10 kHz internal sample rate.
*/
package ovxp_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SAMPLE_PERIOD_NS = 100000;
	localparam int SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_HZ = 1000000000 / SAMPLE_PERIOD_NS;
	localparam int SAMPLES_PER_MS = 1000000 / SAMPLE_PERIOD_NS;
	localparam int VOLT_W = 16;
	localparam int FLUX_W = 32;
	localparam int RATIO_W = 16;
	localparam int TIME_W = 20;
	localparam int CNT_W = 32;
	localparam int DIV_W = 48;
	localparam int PTS = 7;
	localparam int SEG_W = 3;
	localparam int LEAK_SHIFT = 12;
	// ratio units per percent; rated U/f reads as 100 percent
	localparam int PCT_SUB = 100;
	localparam int RATIO_SCALE = 100 * PCT_SUB;
	localparam int DROP_NUM = 95;
	localparam int DROP_DEN = 100;
	localparam int IEEE_K_MILLI = 180;
	localparam logic [DIV_W-1:0] IEEE_NUM =
		DIV_W'(64'(IEEE_K_MILLI) * PCT_SUB * PCT_SUB * SAMPLE_HZ / 1000);
	localparam logic [5:0] TMS_MIN = 6'h01;
	localparam logic [5:0] TMS_MAX = 6'h3C;
	localparam logic [CNT_W-1:0] ACC_FULL = 32'h0100_0000;
	typedef enum logic [1:0] {PAIR_AB, PAIR_BC, PAIR_CA} ovxp_pair_t;
	typedef enum logic [1:0] {MODE_DT, MODE_CUSTOM, MODE_IEEE} ovxp_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RATIO, ST_CURVE, ST_HEAT, ST_COOL, ST_DECIDE
	} ovxp_state_t;
endpackage

// ==== ovxp_div_if.sv ====
/*
 Request and answer carrier between the protection core and its divider.
 Assumes the requester raises start only while no division is running.
*/
`timescale 1ns/1ps
interface ovxp_div_if;
	logic start;
	logic [ovxp_pkg::DIV_W-1:0] dividend;
	logic [ovxp_pkg::DIV_W-1:0] divisor;
	logic done;
	logic [ovxp_pkg::DIV_W-1:0] quotient;
	modport master(output start, output dividend, output divisor, input done, input quotient);
	modport slave(input start, input dividend, input divisor, output done, output quotient);
endinterface

// ==== ovxp_divider.sv ====
/*
 Sequential restoring divider, one quotient bit per clock.
 Assumes start is a single pulse with operands valid in that cycle.
*/
`timescale 1ns/1ps
module ovxp_divider (
	input wire logic ref_clk,
	input wire logic nrst,
	ovxp_div_if.slave div
);
	localparam int DW = ovxp_pkg::DIV_W;
	// accept edge, one edge per quotient bit, then done is registered
	localparam int DIV_LAT = DW + 1;
	logic [DW-1:0] rem;
	logic [DW-1:0] quo;
	logic [DW-1:0] dsr;
	logic [5:0] bitCnt;
	logic busy;
	logic done;
	logic [DW:0] shifted;
	logic [DW:0] trial;

	assign shifted = {rem, quo[DW-1]};
	assign trial = shifted - {1'b0, dsr};
	assign div.quotient = quo;
	assign div.done = done;

	// zero divisor yields all ones, which callers treat as saturation
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rem <= '0;
			quo <= '0;
			dsr <= '0;
			bitCnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (div.start && !busy) begin
				rem <= '0;
				quo <= div.dividend;
				dsr <= div.divisor;
				bitCnt <= '0;
				busy <= 1'b1;
			end else if (busy) begin
				rem <= trial[DW] ? shifted[DW-1:0] : trial[DW-1:0];
				quo <= {quo[DW-2:0], ~trial[DW]};
				bitCnt <= bitCnt + 6'h01;
				if (bitCnt == 6'(DW - 1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	a_div_latency: assert property (@(posedge ref_clk) disable iff (!nrst)
		div.start && !busy |-> ##DIV_LAT done)
		else $error("divider answer not on time");
endmodule

// ==== ovxp_flux.sv ====
/*
 Phase-pair selection, flux integration and half peak-to-peak magnitude.
 Assumes sampleEn is a one-cycle pulse at the fixed sample rate and
 phase samples are steady in that cycle.
*/
`timescale 1ns/1ps
module ovxp_flux (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic sampleEn,
	input wire logic signed [ovxp_pkg::VOLT_W-1:0] voltA,
	input wire logic signed [ovxp_pkg::VOLT_W-1:0] voltB,
	input wire logic signed [ovxp_pkg::VOLT_W-1:0] voltC,
	input wire logic [1:0] pairSel,
	output logic [ovxp_pkg::FLUX_W-1:0] fluxMag,
	output logic magValid
);
	localparam int VW = ovxp_pkg::VOLT_W;
	localparam int FW = ovxp_pkg::FLUX_W;
	logic signed [VW:0] pairVolt;
	logic signed [FW-1:0] flux;
	logic signed [FW-1:0] next_flux;
	logic signed [FW-1:0] posPeak;
	logic signed [FW-1:0] negPeak;
	logic signed [FW:0] span;
	logic rising;
	logic posSeen;
	logic negSeen;

	// no drop compensation: raw phase-pair voltage feeds the integrator
	always_comb begin
		case (ovxp_pkg::ovxp_pair_t'(pairSel))
			ovxp_pkg::PAIR_BC: pairVolt = (VW+1)'(voltB) - (VW+1)'(voltC);
			ovxp_pkg::PAIR_CA: pairVolt = (VW+1)'(voltC) - (VW+1)'(voltA);
			default: pairVolt = (VW+1)'(voltA) - (VW+1)'(voltB);
		endcase
	end

	// small leak bleeds off offset drift; costs slight gain at low frequency
	assign next_flux = flux + FW'(pairVolt) - (flux >>> ovxp_pkg::LEAK_SHIFT);
	assign span = {posPeak[FW-1], posPeak} - {negPeak[FW-1], negPeak};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			flux <= '0;
			rising <= 1'b0;
			posPeak <= '0;
			negPeak <= '0;
			posSeen <= 1'b0;
			negSeen <= 1'b0;
		end else if (sampleEn) begin
			flux <= next_flux;
			if (next_flux > flux) begin
				rising <= 1'b1;
				if (!rising) begin
					negPeak <= flux;
					negSeen <= 1'b1;
				end
			end else if (next_flux < flux) begin
				rising <= 1'b0;
				if (rising) begin
					posPeak <= flux;
					posSeen <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fluxMag <= '0;
			magValid <= 1'b0;
		end else if (sampleEn) begin
			fluxMag <= (posSeen && negSeen) ? span[FW:1] : '0;
			magValid <= posSeen && negSeen;
		end
	end

	a_peak_pair: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(posSeen && negSeen) |=> !magValid && fluxMag == '0)
		else $error("magnitude reported before both peaks");
endmodule

// ==== ovxp_source.sv ====
/*
 Stand-in for the voltage sampling front end: square wave on phase A,
 phases B and C held at zero. Assumes the core samples every SDIV clocks.
*/
`timescale 1ns/1ps
module ovxp_source #(
	parameter int SDIV = 256
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic signed [ovxp_pkg::VOLT_W-1:0] amp,
	output logic signed [ovxp_pkg::VOLT_W-1:0] voltA,
	output logic signed [ovxp_pkg::VOLT_W-1:0] voltB,
	output logic signed [ovxp_pkg::VOLT_W-1:0] voltC
);
	// half period of four samples keeps the peak search short
	int cnt;
	logic pos;
	always @(negedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			pos <= 1'b1;
		end else if (cnt == 4 * SDIV - 1) begin
			cnt <= 0;
			pos <= !pos;
		end else begin
			cnt <= cnt + 1;
		end
	end
	assign voltA = pos ? amp : -amp;
	assign voltB = '0;
	assign voltC = '0;
endmodule

// ==== testbench.sv ====
/*
 Self-checking bench of the overexcitation core: a table of setting rows,
 then drop-off, multiplier and cooling cases. Assumes the square-wave source model.
*/
`timescale 1ns/1ps
module testbench;
	localparam int SDIV = 256;
	localparam int LIMIT = 95000;
	localparam logic [31:0] R1 = 32'h0000_0001;
	localparam logic [31:0] RH = 32'hFFFF_FFFF;
	typedef struct {
		logic [1:0] md;
		logic [1:0] pr;
		logic [31:0] rated;
		logic [15:0] up;
		logic [15:0] thr;
		logic [19:0] dt;
		logic [19:0] mn;
		logic [19:0] mx;
		logic st;
		logic al;
		logic tr;
	} ovxp_row_t;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic signed [15:0] amp = 16'sh03E8;
	logic signed [15:0] voltA;
	logic signed [15:0] voltB;
	logic signed [15:0] voltC;
	logic [1:0] pairSel = 2'h0;
	logic [31:0] ratedFlux = R1;
	logic [1:0] mode = 2'h0;
	logic [15:0] upper = 16'h2AF8;
	logic [15:0] lower = 16'h0064;
	logic [19:0] dtDelayMs = 20'h00001;
	logic [19:0] minDelayMs = 20'h00000;
	logic [19:0] maxDelayMs = 20'h00014;
	logic [5:0] timeMult = 6'h01;
	logic [19:0] dropOffMs = 20'h00001;
	logic [19:0] coolTimeMs = 20'h00000;
	logic [ovxp_pkg::PTS-1:0][ovxp_pkg::RATIO_W-1:0] curveRatio = '0;
	logic [ovxp_pkg::PTS-1:0][ovxp_pkg::TIME_W-1:0] curveDelayMs = '0;
	logic [31:0] fluxMagnitude;
	logic [15:0] ratioPct;
	logic [31:0] thermalLevel;
	logic startOut;
	logic alarmOut;
	logic tripOut;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	ovxp_row_t rows [10];

	always #5 ref_clk = ~ref_clk;

	ovxp_source #(.SDIV(SDIV)) u_src (.ref_clk(ref_clk), .nrst(nrst), .amp(amp),
		.voltA(voltA), .voltB(voltB), .voltC(voltC));

	ovxp_protection #(.SAMPLE_DIV(SDIV)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
		.phaseVoltA(voltA), .phaseVoltB(voltB), .phaseVoltC(voltC), .pairSel(pairSel),
		.ratedFlux(ratedFlux), .mode(mode), .upperPickupRatio(upper),
		.lowerPickupRatio(lower), .timeMult(timeMult), .dtDelayMs(dtDelayMs),
		.dropOffMs(dropOffMs), .minDelayMs(minDelayMs), .maxDelayMs(maxDelayMs),
		.coolTimeMs(coolTimeMs), .alarmDelayMs(20'h00001), .curveRatio(curveRatio),
		.curveDelayMs(curveDelayMs), .fluxMagnitude(fluxMagnitude), .ratioPct(ratioPct),
		.thermalLevel(thermalLevel), .startOut(startOut), .alarmOut(alarmOut),
		.tripOut(tripOut));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			results();
		end
	end

	task automatic do_reset();
		@(negedge ref_clk);
		nrst = 1'b0;
		repeat (12) @(negedge ref_clk);
		check("reset flags", {29'h0, startOut, alarmOut, tripOut}, 32'h0);
		check("reset level", thermalLevel, 32'h0);
		check("reset flux", fluxMagnitude, 32'h0);
		nrst = 1'b1;
	endtask

	// settings are applied just before do_reset asserts reset, so the pipeline restarts on them steady
	task automatic apply(input ovxp_row_t r);
		mode = r.md;
		pairSel = r.pr;
		ratedFlux = r.rated;
		upper = r.up;
		lower = r.thr;
		dtDelayMs = r.dt;
		minDelayMs = r.mn;
		maxDelayMs = r.mx;
		for (int i = 0; i < ovxp_pkg::PTS; i++) begin
			curveRatio[i] = r.thr + ((r.thr == 16'hFFFF) ? 16'h0 : 16'(i));
			curveDelayMs[i] = r.mx;
		end
	endtask

	task automatic wait_samples(input int n);
		repeat (n * SDIV + 230) @(negedge ref_clk);
	endtask

	initial begin
		rows[0] = '{2'h0, 2'h0, R1, 16'h2AF8, 16'h0064, 20'h1, 20'h0, 20'h14, 1'h1, 1'h1, 1'h1};
		rows[1] = '{2'h0, 2'h0, RH, 16'h2AF8, 16'h0064, 20'h1, 20'h0, 20'h14, 1'h0, 1'h0, 1'h0};
		rows[2] = '{2'h0, 2'h0, R1, 16'h2AF8, 16'h0064, 20'h14, 20'h0, 20'h14, 1'h1, 1'h1, 1'h0};
		rows[3] = '{2'h0, 2'h1, R1, 16'h2AF8, 16'h0064, 20'h1, 20'h0, 20'h14, 1'h0, 1'h0, 1'h0};
		rows[4] = '{2'h0, 2'h2, R1, 16'h2AF8, 16'h0064, 20'h1, 20'h0, 20'h14, 1'h1, 1'h1, 1'h1};
		rows[5] = '{2'h1, 2'h0, R1, 16'hFFFF, 16'h0064, 20'h14, 20'h0, 20'h1, 1'h1, 1'h1, 1'h1};
		rows[6] = '{2'h1, 2'h0, R1, 16'hFFFF, 16'hFFFF, 20'h1, 20'h0, 20'h1, 1'h0, 1'h0, 1'h0};
		rows[7] = '{2'h1, 2'h0, R1, 16'h2AF8, 16'h0064, 20'h1, 20'h0, 20'h14, 1'h1, 1'h1, 1'h1};
		rows[8] = '{2'h2, 2'h0, R1, 16'hFF00, 16'h0064, 20'h14, 20'h0, 20'h1, 1'h1, 1'h1, 1'h1};
		rows[9] = '{2'h2, 2'h0, R1, 16'h0064, 16'h0064, 20'h1, 20'h14, 20'h14, 1'h1, 1'h1, 1'h0};
		for (int k = 0; k < 10; k++) begin
			apply(rows[k]);
			do_reset();
			wait_samples(24);
			check("start", {31'h0, startOut}, {31'h0, rows[k].st});
			check("alarm", {31'h0, alarmOut}, {31'h0, rows[k].al});
			check("trip", {31'h0, tripOut}, {31'h0, rows[k].tr});
			check("ratio", {16'h0, ratioPct},
				(rows[k].rated == R1 && rows[k].pr != 2'h1) ? 32'hFFFF : 32'h0);
			$display("row %0d done", k);
		end
		// short dip keeps the definite timer, a long one clears it
		apply(rows[0]);
		do_reset();
		wait_samples(24);
		ratedFlux = RH;
		repeat (3 * SDIV) @(negedge ref_clk);
		check("short drop trip", {31'h0, tripOut}, 32'h0);
		ratedFlux = R1;
		repeat (3 * SDIV) @(negedge ref_clk);
		check("timer kept", {31'h0, tripOut}, 32'h1);
		ratedFlux = RH;
		repeat (15 * SDIV) @(negedge ref_clk);
		ratedFlux = R1;
		repeat (3 * SDIV) @(negedge ref_clk);
		check("restarted", {31'h0, startOut}, 32'h1);
		check("timer cleared", {31'h0, tripOut}, 32'h0);
		$display("drop-off test done");
		// multiplier 63 acts as 60: 120 samples, first step full scale / 120
		apply(rows[8]);
		upper = 16'hF447;
		maxDelayMs = 20'h00014;
		timeMult = 6'h3F;
		do_reset();
		@(thermalLevel);
		@(negedge ref_clk);
		check("clamped step", thermalLevel, 32'h0002_2222);
		timeMult = 6'h01;
		$display("multiplier test done");
		// 1 ms cooling is ten samples, one tenth of full scale each
		apply(rows[5]);
		coolTimeMs = 20'h00001;
		do_reset();
		wait_samples(24);
		check("heat", thermalLevel, ovxp_pkg::ACC_FULL);
		ratedFlux = RH;
		@(thermalLevel);
		@(negedge ref_clk);
		check("cool step", thermalLevel, 32'h00E6_6667);
		repeat (12 * SDIV) @(negedge ref_clk);
		check("cooled", thermalLevel, 32'h0);
		check("start dropped", {31'h0, startOut}, 32'h0);
		check("trip dropped", {31'h0, tripOut}, 32'h0);
		$display("cooling test done");
		results();
	end
endmodule
